// ---- inc/cpu_bus_pkg.sv ----
package cpu_bus_pkg;
  // Interrupt vectors, emulation and native
  localparam logic [23:0] NMI_VEC_EMU = 24'h00fffa;
  localparam logic [23:0] NMI_VEC_NAT = 24'h00ffea;
  localparam logic [23:0] IRQ_VEC_EMU = 24'h00fffe;
  localparam logic [23:0] IRQ_VEC_NAT = 24'h00ffee;
  // Locked tail length by accumulator width
  localparam logic [2:0] LOCK_CYC_M8 = 3'h3;
  localparam logic [2:0] LOCK_CYC_M16 = 3'h5;
  localparam logic [2:0] LOCK_NONE = 3'h0;
  // Idle level of active-low pins in the synchronisers
  localparam logic [1:0] SYNC_IDLE = 2'h3;

  // Processor activity
  typedef enum logic [1:0] {
    MODE_RUN = 2'b00,
    MODE_WAIT = 2'b01,
    MODE_STOP = 2'b10
  } mode_t;

  // Status flags from the core
  typedef struct packed {
    logic emu;      // Emulation mode
    logic m_8bit;   // Accumulator width flag, status bit 5
    logic x_8bit;   // Index width flag, status bit 4
    logic irq_dis;  // Maskable interrupt disable
  } flags_t;

  // Sequencing events from the core, one-cycle pulses except cycle_rd and rw_rd
  typedef struct packed {
    logic rmw_tail;   // Locked tail of a memory RMW begins
    logic instr_done; // Current instruction completes
    logic wai_exec;   // Wait-for-interrupt executed
    logic stp_exec;   // Stop executed
    logic cycle_rd;   // Current bus cycle is a read
    logic rw_rd;      // Direction of the next bus cycle, 1 = read
  } core_evt_t;

  // Whole state of the control block
  typedef struct packed {
    logic [1:0] phi2_sy;
    logic phi2_prev;
    logic [1:0] nmi_sy;
    logic nmi_prev;
    logic [1:0] irq_sy;
    logic [1:0] abort_sy;
    logic abort_prev;
    logic [1:0] rdy_sy;
    logic [1:0] init_sy;
    mode_t mode;
    logic nmi_pend;
    logic [2:0] lock_cnt;
    logic lock_n;
    logic mx;
    logic phi1;
    logic phi2;
    logic rw;
    logic nmi_take;
    logic irq_take;
    logic wake_cont;
    logic [23:0] vector;
    logic advance;
  } state_t;

  localparam state_t STATE_RST = '{
    phi2_sy: SYNC_IDLE, phi2_prev: 1'b1, nmi_sy: SYNC_IDLE,
    nmi_prev: 1'b1, irq_sy: SYNC_IDLE, abort_sy: SYNC_IDLE,
    abort_prev: 1'b1, rdy_sy: SYNC_IDLE, init_sy: SYNC_IDLE,
    mode: MODE_RUN, lock_cnt: LOCK_NONE, lock_n: 1'b1, phi2: 1'b1,
    rw: 1'b1, vector: NMI_VEC_EMU, default: '0
  };
endpackage

// ---- core/cpu_bus_ctrl.sv ----
module cpu_bus_ctrl (
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic clk_en,
  // Core side
  input wire cpu_bus_pkg::flags_t flags,
  input wire cpu_bus_pkg::core_evt_t evt,
  input wire logic byte_bus,
  input wire logic mux_bus,
  output logic cpu_advance,
  output logic nmi_take,
  output logic irq_take,
  output logic wake_cont,
  output logic [23:0] vector,
  // Interrupt and reset pins
  input wire logic nmi_n,
  input wire logic irq_n,
  input wire logic abort_n,
  input wire logic chip_init_n,
  // Clock pins
  input wire logic phi2_in,
  output logic phi1_out,
  output logic phi2_out,
  // Bus control pins
  input wire logic bus_drive_enable,
  output logic rw_out,
  output logic rw_oe,
  output logic addr_oe,
  output logic data_oe,
  output logic rmw_lock_n,
  output logic mx_status,
  // Ready pin, two-way
  input wire logic rdy_in,
  output logic rdy_out,
  output logic rdy_oe
);

  cpu_bus_pkg::state_t st_reg; // All state
  cpu_bus_pkg::state_t st_next; // Its next value
  logic nmi_edge; // Synchronised NMI fell
  logic abort_edge; // Synchronised abort fell
  logic phi2_fall; // Synchronised phase-2 fell
  logic irq_lvl; // Request held low
  logic init_act; // Chip init held low
  logic halt; // Ready holds the core
  logic nmi_now; // NMI pending or arriving
  logic service; // Interrupt may be taken now
  logic wake; // Any wake source
  logic bus_on; // Buffers allowed to drive

  // Tail length from accumulator width
  function automatic logic [2:0] lock_len(input logic m8);
    lock_len = m8 ? cpu_bus_pkg::LOCK_CYC_M8 : cpu_bus_pkg::LOCK_CYC_M16;
  endfunction

  // Vector for a given source and mode
  function automatic logic [23:0] vec_sel(input logic nmi,
                                          input logic emu);
    if (nmi) begin
      vec_sel = emu ? cpu_bus_pkg::NMI_VEC_EMU : cpu_bus_pkg::NMI_VEC_NAT;
    end else begin
      vec_sel = emu ? cpu_bus_pkg::IRQ_VEC_EMU : cpu_bus_pkg::IRQ_VEC_NAT;
    end
  endfunction

  // Decoded conditions, pin inputs taken from second-stage flops
  always_comb begin
    nmi_edge = st_reg.nmi_prev & ~st_reg.nmi_sy[1];
    abort_edge = st_reg.abort_prev & ~st_reg.abort_sy[1];
    phi2_fall = st_reg.phi2_prev & ~st_reg.phi2_sy[1];
    irq_lvl = ~st_reg.irq_sy[1];
    init_act = ~st_reg.init_sy[1];
    // Ready ignored while chip init is held
    halt = ~st_reg.rdy_sy[1] & ~init_act &
           (~(flags.emu & byte_bus) | evt.cycle_rd);
    nmi_now = st_reg.nmi_pend | nmi_edge;
    // Waiting skips the end-of-instruction wait
    service = evt.instr_done |
              (st_reg.mode == cpu_bus_pkg::MODE_WAIT);
    wake = init_act | abort_edge | nmi_edge | irq_lvl;
  end

  // Next-state logic; frozen while clock enable is low
  always_comb begin
    st_next = st_reg;
    if (clk_en) begin
      // Two-flop synchronisers for every pin input except the bus enable
      st_next.phi2_sy = {st_reg.phi2_sy[0], phi2_in};
      st_next.nmi_sy = {st_reg.nmi_sy[0], nmi_n};
      st_next.irq_sy = {st_reg.irq_sy[0], irq_n};
      st_next.abort_sy = {st_reg.abort_sy[0], abort_n};
      st_next.rdy_sy = {st_reg.rdy_sy[0], rdy_in};
      st_next.init_sy = {st_reg.init_sy[0], chip_init_n};
      st_next.phi2_prev = st_reg.phi2_sy[1];
      st_next.nmi_prev = st_reg.nmi_sy[1];
      st_next.abort_prev = st_reg.abort_sy[1];
      // Pulses default low
      st_next.nmi_take = 1'b0;
      st_next.irq_take = 1'b0;
      st_next.wake_cont = 1'b0;
      // Core steps on each phase-2 fall unless held
      st_next.advance = phi2_fall & ~halt &
                        (st_reg.mode == cpu_bus_pkg::MODE_RUN);
      // Locked tail counts core cycles down to zero
      if (evt.rmw_tail) begin
        st_next.lock_cnt = lock_len(flags.m_8bit);
      end else if (st_reg.advance &&
                   st_reg.lock_cnt != cpu_bus_pkg::LOCK_NONE) begin
        st_next.lock_cnt = st_reg.lock_cnt - 3'h1;
      end
      st_next.lock_n =
        (st_next.lock_cnt == cpu_bus_pkg::LOCK_NONE);
      // X while phase-2 is high, M while it is low
      st_next.mx = st_reg.phi2_sy[1] ? flags.x_8bit
                                     : flags.m_8bit;
      // Clock outputs, parked when stopped
      if (st_reg.mode == cpu_bus_pkg::MODE_STOP) begin
        st_next.phi1 = 1'b0;
        st_next.phi2 = 1'b1;
      end else begin
        st_next.phi1 = ~st_reg.phi2_sy[1];
        st_next.phi2 = st_reg.phi2_sy[1];
      end
      st_next.rw = evt.rw_rd;
      // NMI wins over the maskable request
      if (nmi_now && service) begin
        st_next.nmi_take = 1'b1;
        st_next.vector = vec_sel(1'b1, flags.emu);
        // A fresh edge behind a taken one stays pending
        st_next.nmi_pend = st_reg.nmi_pend & nmi_edge;
      end else begin
        st_next.nmi_pend = nmi_now;
        if (irq_lvl && !flags.irq_dis && service) begin
          st_next.irq_take = 1'b1;
          st_next.vector = vec_sel(1'b0, flags.emu);
        end
      end
      // Activity state machine
      case (st_reg.mode)
        cpu_bus_pkg::MODE_RUN: begin
          if (evt.wai_exec) begin
            st_next.mode = cpu_bus_pkg::MODE_WAIT;
          end else if (evt.stp_exec) begin
            st_next.mode = cpu_bus_pkg::MODE_STOP;
          end
        end
        cpu_bus_pkg::MODE_WAIT: begin
          // Any wake source releases ready
          if (wake) begin
            st_next.mode = cpu_bus_pkg::MODE_RUN;
            // Masked request alone: carry on, no vector
            if (irq_lvl && flags.irq_dis && !nmi_now &&
                !abort_edge && !init_act) begin
              st_next.wake_cont = 1'b1;
            end
          end
        end
        cpu_bus_pkg::MODE_STOP: begin
          // Only chip init restarts a stopped core
          if (init_act) begin
            st_next.mode = cpu_bus_pkg::MODE_RUN;
          end
        end
        default: begin
          st_next.mode = cpu_bus_pkg::MODE_RUN;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_reg <= cpu_bus_pkg::STATE_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // On the mux bus, bus enable gates the drivers directly: it is asynchronous, so a
  // synchroniser here would let the buffers fight for two cycles
  always_comb begin
    bus_on = ~mux_bus | bus_drive_enable;
    rw_oe = bus_on;
    addr_oe = bus_on;
    // Mux bus: address in first half, store data on writes
    data_oe = bus_on & (~st_reg.rw |
              (mux_bus & ~st_reg.phi2_sy[1]));
  end

  // Registered outputs
  assign cpu_advance = st_reg.advance;
  assign nmi_take = st_reg.nmi_take;
  assign irq_take = st_reg.irq_take;
  assign wake_cont = st_reg.wake_cont;
  assign vector = st_reg.vector;
  assign phi1_out = st_reg.phi1;
  assign phi2_out = st_reg.phi2;
  assign rw_out = st_reg.rw;
  assign rmw_lock_n = st_reg.lock_n;
  assign mx_status = st_reg.mx;
  // Ready pulled low only while waiting, never by stop
  assign rdy_out = 1'b0;
  assign rdy_oe = (st_reg.mode == cpu_bus_pkg::MODE_WAIT);

  // Checks on the driven outputs
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst || !clk_en);

  lock_short_a: assert property (evt.rmw_tail && flags.m_8bit |=>
    !rmw_lock_n && st_reg.lock_cnt == 3'h3)
    else $error("lock tail not three cycles");
  lock_long_a: assert property (evt.rmw_tail && !flags.m_8bit |=>
    !rmw_lock_n && st_reg.lock_cnt == 3'h5)
    else $error("lock tail not five cycles");
  lock_idle_a: assert property (st_reg.lock_cnt == 3'h0 &&
    !evt.rmw_tail |=> rmw_lock_n)
    else $error("lock low outside tail");
  mx_mux_a: assert property (st_reg.phi2_sy[1] |=>
    mx_status == $past(flags.x_8bit))
    else $error("status pin not index flag");
  nmi_edge_a: assert property (nmi_edge && !service |=>
    st_reg.nmi_pend)
    else $error("nmi edge lost");
  nmi_vec_a: assert property (nmi_take |->
    vector == ($past(flags.emu) ? 24'h00fffa : 24'h00ffea))
    else $error("nmi vector wrong");
  nmi_level_a: assert property (!st_reg.nmi_pend && !nmi_edge &&
    !nmi_n |=> !nmi_take)
    else $error("steady nmi low raised interrupt");
  wai_fast_a: assert property (st_reg.mode == cpu_bus_pkg::MODE_WAIT &&
    nmi_edge |=> nmi_take)
    else $error("waiting nmi not taken at once");
  stop_clk_a: assert property (st_reg.mode ==
    cpu_bus_pkg::MODE_STOP |=> !phi1_out && phi2_out)
    else $error("clocks not parked in stop");
  rw_dir_a: assert property (##1 rw_out == $past(evt.rw_rd))
    else $error("direction pin wrong");
  rw_float_a: assert property (mux_bus && !bus_drive_enable |->
    !rw_oe && !addr_oe && !data_oe)
    else $error("buffers drive while disabled");
  rdy_halt_a: assert property (halt |=> !cpu_advance)
    else $error("core advanced while ready low");
  wai_pull_a: assert property (evt.wai_exec &&
    st_reg.mode == cpu_bus_pkg::MODE_RUN |=> rdy_oe && !rdy_out)
    else $error("ready not pulled by wait");
  irq_mask_a: assert property (st_reg.mode == cpu_bus_pkg::MODE_WAIT &&
    irq_lvl && flags.irq_dis && !nmi_now && !abort_edge && !init_act
    |=> wake_cont && !irq_take && !rdy_oe)
    else $error("masked request did not resume");
  stp_rdy_a: assert property (evt.stp_exec && !evt.wai_exec &&
    st_reg.mode == cpu_bus_pkg::MODE_RUN |=> ##[1:4] !rdy_oe)
    else $error("stop touched ready");

  // Secondary checks on vectoring, clocks, drivers and the hold paths
  irq_vec_a: assert property (irq_take |->
    vector == ($past(flags.emu) ? 24'h00fffe : 24'h00ffee))
    else $error("irq vector wrong");
  phi_inv_a: assert property (st_reg.mode != cpu_bus_pkg::MODE_STOP |=>
    phi1_out == !phi2_out)
    else $error("phase-1 not inverse of phase-2");
  oe_plain_a: assert property (!mux_bus |->
    rw_oe && addr_oe)
    else $error("plain bus drivers disabled");
  data_wr_a: assert property (bus_on && !rw_out |->
    data_oe)
    else $error("store data not driven");
  init_rdy_a: assert property (init_act && phi2_fall &&
    st_reg.mode == cpu_bus_pkg::MODE_RUN |=> cpu_advance)
    else $error("ready acted during chip init");
  wait_hold_a: assert property (st_reg.mode ==
    cpu_bus_pkg::MODE_WAIT |=> !cpu_advance)
    else $error("core advanced while waiting");
  wake_rdy_a: assert property (st_reg.mode ==
    cpu_bus_pkg::MODE_WAIT && nmi_edge |=> !rdy_oe)
    else $error("ready not released on nmi");
  stop_stay_a: assert property (st_reg.mode ==
    cpu_bus_pkg::MODE_STOP && !init_act |=> phi2_out && !phi1_out)
    else $error("stopped clocks released");
  // Cover points for the main scenarios
  lock_seq_c: cover property (evt.rmw_tail ##1 !rmw_lock_n [*3]);
  wai_nmi_c: cover property (evt.wai_exec ##[1:50] nmi_take);
  stop_c: cover property (evt.stp_exec ##[1:20] phi2_out [*4]);
  wai_mask_c: cover property (rdy_oe ##[1:50] wake_cont);

endmodule

// ---- tb/bus_partner.sv ----
module bus_partner (
  // Clock and stimulus controls
  input wire logic ref_clk,
  input wire logic standby,
  input wire logic rdy_hold_n,
  // Device side
  input wire logic rdy_out,
  input wire logic rdy_oe,
  input wire logic rmw_lock_n,
  output logic phi2_in,
  output logic rdy_in,
  output logic arb_ok
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] div_reg = 2'h0; // Half period counter
  initial phi2_in = 1'h1;
  // Phase-2 source, eight system clocks a period
  always @(posedge ref_clk) begin
    div_reg <= div_reg + 2'h1;
    // Standby holds the clock high to keep state
    if (standby) begin
      phi2_in <= 1'h1;
    end else if (div_reg == 2'h3) begin
      phi2_in <= ~phi2_in;
    end
  end
  // Ready wire has a pull-up; either party may pull it low
  assign rdy_in = (rdy_oe ? rdy_out : 1'h1) & rdy_hold_n;
  // Arbiter defers the next bus cycle while locked
  assign arb_ok = rmw_lock_n;
endmodule

// ---- tb/testbench.sv ----
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, srst, byte_bus, mux_bus, nmi_n, irq_n, chip_init_n;
  logic bus_drive_enable, standby, rdy_hold_n, phi2_in, rdy_in, arb_ok;
  logic cpu_advance, nmi_take, irq_take, wake_cont, phi1_out, phi2_out;
  logic rw_out, rw_oe, addr_oe, data_oe, rmw_lock_n, mx_status;
  logic rdy_out, rdy_oe;
  logic [23:0] vector; // Vector seen by the core
  cpu_bus_pkg::flags_t flags; // Core status levels
  cpu_bus_pkg::core_evt_t evt; // Core events, index 5 down to 0
  int err_total = 0;
  int checks = 0;
  cpu_bus_ctrl i_dut (.ref_clk(ref_clk), .srst(srst), .clk_en(1'h1),
    .flags(flags), .evt(evt), .byte_bus(byte_bus), .mux_bus(mux_bus),
    .cpu_advance(cpu_advance), .nmi_take(nmi_take), .irq_take(irq_take),
    .wake_cont(wake_cont), .vector(vector), .nmi_n(nmi_n), .irq_n(irq_n),
    .abort_n(1'h1), .chip_init_n(chip_init_n), .phi2_in(phi2_in),
    .phi1_out(phi1_out), .phi2_out(phi2_out),
    .bus_drive_enable(bus_drive_enable), .rw_out(rw_out), .rw_oe(rw_oe),
    .addr_oe(addr_oe), .data_oe(data_oe), .rmw_lock_n(rmw_lock_n),
    .mx_status(mx_status), .rdy_in(rdy_in), .rdy_out(rdy_out),
    .rdy_oe(rdy_oe));
  bus_partner i_far (.ref_clk(ref_clk), .standby(standby),
    .rdy_hold_n(rdy_hold_n), .rdy_out(rdy_out), .rdy_oe(rdy_oe),
    .rmw_lock_n(rmw_lock_n), .phi2_in(phi2_in), .rdy_in(rdy_in),
    .arb_ok(arb_ok));
  // System clock
  initial begin
    ref_clk = 1'h0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Value compare, one line on a mismatch
  task automatic chk(input string nm, input logic [23:0] e,
      input logic [23:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Step to later falling edges, where inputs change
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // One-cycle event pulse
  task automatic fire(input int k);
    evt[k] = 1'h1;
    tick(1);
    evt[k] = 1'h0;
  endtask
  // Count advance pulses over n cycles
  task automatic adv(input int n, output int c);
    c = 0;
    repeat (n) begin
      if (cpu_advance === 1'h1) c++;
      tick(1);
    end
  endtask
  // Status mux and phase-1 against stable phase-2 samples
  task automatic t_clk();
    logic p;
    flags.m_8bit = 1'h1;
    flags.x_8bit = 1'h0;
    repeat (20) begin
      p = phi2_out;
      tick(1);
      if (phi2_out === p) begin
        chk("mx", p ? flags.x_8bit : flags.m_8bit, mx_status);
        chk("phi1", !p, phi1_out);
      end
    end
  endtask
  // Locked tail spans exactly n advances
  task automatic t_lock(input logic m8, input int n);
    int c;
    c = 0;
    flags.m_8bit = m8;
    fire(5);
    chk("lock_on", 1'h0, rmw_lock_n);
    for (int i = 0; i < 90 && rmw_lock_n === 1'h0; i++) begin
      if (cpu_advance === 1'h1) c++;
      tick(1);
    end
    chk("lock_len", n, c);
    chk("lock_off", 1'h1, rmw_lock_n);
    chk("arb", 1'h1, arb_ok);
  endtask
  // Direction and bus enable, enable is not clocked
  task automatic t_bus();
    evt.rw_rd = 1'h0;
    tick(2);
    chk("rw_wr", 1'h0, rw_out);
    mux_bus = 1'h1;
    bus_drive_enable = 1'h0;
    #1;
    chk("rw_oe", 1'h0, rw_oe);
    chk("addr_oe", 1'h0, addr_oe);
    chk("data_oe", 1'h0, data_oe);
    bus_drive_enable = 1'h1;
    #1;
    chk("rw_oe_on", 1'h1, rw_oe);
    chk("data_oe_wr", 1'h1, data_oe);
    evt.rw_rd = 1'h1;
    tick(2);
    chk("rw_rd", 1'h1, rw_out);
    mux_bus = 1'h0;
  endtask
  // Edge taken at instruction end, steady low ignored
  task automatic t_nmi(input logic emu, input logic [23:0] v);
    logic hit;
    flags.emu = emu;
    nmi_n = 1'h0;
    tick(4);
    fire(4);
    for (int i = 0; i < 12 && nmi_take !== 1'h1; i++) tick(1);
    chk("nmi_take", 1'h1, nmi_take);
    chk("nmi_vec", v, vector);
    hit = 1'h0;
    fire(4);
    repeat (10) begin
      hit |= nmi_take;
      tick(1);
    end
    chk("nmi_low", 1'h0, hit);
    nmi_n = 1'h1;
    tick(3);
  endtask
  // Level request, then masked request ignored
  task automatic t_irq();
    flags = '0;
    irq_n = 1'h0;
    tick(4);
    fire(4);
    for (int i = 0; i < 12 && irq_take !== 1'h1; i++) tick(1);
    chk("irq_vec", 24'h00ffee, irq_take ? vector : 24'h0);
    flags.irq_dis = 1'h1;
    fire(4);
    chk("irq_mask", 1'h0, irq_take);
    tick(1);
    chk("irq_mask", 1'h0, irq_take);
    irq_n = 1'h1;
    tick(3);
  endtask
  // Waiting: ready pulled low, woken without instruction end
  task automatic t_wait();
    fire(3);
    chk("rdy_oe", 1'h1, rdy_oe);
    chk("rdy_line", 1'h0, rdy_in);
    irq_n = 1'h0;
    for (int i = 0; i < 8 && wake_cont !== 1'h1; i++) tick(1);
    chk("wake", 1'h1, wake_cont);
    chk("wake_irq", 1'h0, irq_take);
    chk("rdy_free", 1'h0, rdy_oe);
    irq_n = 1'h1;
    tick(3);
    fire(3);
    nmi_n = 1'h0;
    for (int i = 0; i < 8 && nmi_take !== 1'h1; i++) tick(1);
    chk("wait_nmi", 1'h1, nmi_take);
    nmi_n = 1'h1;
    tick(3);
  endtask
  // External ready low halts; byte bus emulation only on reads
  task automatic t_ready();
    int c;
    rdy_hold_n = 1'h0;
    tick(3);
    adv(24, c);
    chk("halt", 24'h0, c);
    flags.emu = 1'h1;
    byte_bus = 1'h1;
    adv(24, c);
    chk("emu_write", 1'h1, c != 0);
    evt.cycle_rd = 1'h1;
    tick(2);
    adv(24, c);
    chk("emu_read", 24'h0, c);
    rdy_hold_n = 1'h1;
    adv(14, c);
    chk("resume", 1'h1, c != 0);
    byte_bus = 1'h0;
  endtask
  // Stop freezes both clock outputs, ready untouched
  task automatic t_stop();
    fire(2);
    tick(1);
    standby = 1'h1;
    repeat (20) begin
      chk("phi1_stp", 1'h0, phi1_out);
      chk("phi2_stp", 1'h1, phi2_out);
      chk("rdy_stp", 1'h0, rdy_oe);
      tick(1);
    end
    chip_init_n = 1'h0;
    standby = 1'h0;
    tick(6);
    chip_init_n = 1'h1;
  endtask
  // Verdict, reached from the sequence or the watchdog
  task automatic tally_and_finish();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Watchdog, tests need about 300 cycles
  initial begin
    #100000;
    err_total++;
    tally_and_finish();
  end
  // Main sequence
  initial begin
    {srst, nmi_n, irq_n, chip_init_n, rdy_hold_n} = 5'h1f;
    {byte_bus, mux_bus, standby, bus_drive_enable} = 4'h1;
    flags = '0;
    evt = '0;
    evt.rw_rd = 1'h1;
    tick(5);
    srst = 1'h0;
    chk("lock_rst", 1'h1, rmw_lock_n);
    chk("vec_rst", 24'h00fffa, vector);
    tick(3);
    t_clk();
    t_lock(1'h1, 3);
    t_lock(1'h0, 5);
    t_bus();
    t_nmi(1'h0, 24'h00ffea);
    t_nmi(1'h1, 24'h00fffa);
    t_irq();
    t_wait();
    t_ready();
    t_stop();
    tally_and_finish();
  end
endmodule
